/* logic/ads_regs.sv */
/*
 register side and sequencer of the 10-bit eight-input converter:
 result registers, control/status, trigger control, conversion timing.
 assumes the analogue macro presents a settled result on ana_result by
 the last state of a conversion, and an 8-bit bus whose reads and writes
 are one-cycle strobes on clock.
*/
`timescale 1ns/100ps
module ads_regs
   import ads_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 standby,
   input  wire logic                 periph_half,
   input  wire logic [15:0]          bus_addr,
   input  wire logic [7:0]           bus_wdata,
   input  wire logic                 bus_wr,
   input  wire logic                 bus_rd,
   output logic      [7:0]           bus_rdata,
   output logic                      bus_rvalid,
   input  wire logic                 ext_start_pin,
   input  wire logic [RES_WIDTH-1:0] ana_result,
   output logic      [2:0]           analog_channel,
   output logic                      conv_active,
   output logic                      end_of_conversion_irq
);
   typedef enum logic {st_idle, st_run} ads_state_t;

   ads_state_t  state;
   logic        conversion_end_flag;
   logic        end_irq_enable;
   logic        conversion_start_bit;
   logic        scan_mode;
   logic        speed_select;
   logic [2:0]  channel_select;
   logic        ext_start_enable;
   logic        flag_armed;
   logic        next_start;
   logic        half_phase;
   logic        state_tick;
   logic [8:0]  cnt;
   logic [1:0]  scan_idx;
   logic [2:0]  conv_idx;
   logic        conv_done;
   logic        scan_last;
   logic        flag_set;
   logic        trig_fall;
   logic        csr_wr;
   logic        csr_rd;
   logic        rd_q;
   logic [15:0] rd_addr_q;
   logic [15:0] mem_q;
   logic [7:0]  temp_low;
   logic [7:0]  csr_value;
   logic [7:0]  trg_value;
   logic        res_hit;

   assign csr_wr = bus_wr && bus_addr == ADDR_CSR;
   assign csr_rd = bus_rd && bus_addr == ADDR_CSR;
   assign csr_value = {conversion_end_flag, end_irq_enable, conversion_start_bit,
                       scan_mode, speed_select, channel_select};
   assign trg_value = {ext_start_enable, TRG_RESERVED};

   // falling edge on the start pin, already gated by the enable bit
   ads_trig_edge u_trig (
      .clock  (clock),
      .rst    (rst),
      .pin    (ext_start_pin),
      .enable (ext_start_enable),
      .fall   (trig_fall)
   );

   // state enable: every clock, or every other clock at half peripheral rate
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         half_phase <= 1'b0;
      else
         half_phase <= !half_phase;
   end
   assign state_tick = !periph_half || half_phase;

   // channel under conversion: whole select field, or group plus scan index
   assign conv_idx  = scan_mode ? {channel_select[CSR_GROUP], scan_idx}
                                : channel_select;
   assign scan_last = scan_idx == channel_select[1:0];
   assign conv_done = state == st_run && conversion_start_bit && state_tick && cnt == 9'd1;
   assign flag_set  = conv_done && (!scan_mode || scan_last);

   // start bit: engine clears it, then software, then the pin; pin wins
   always_comb begin
      next_start = conversion_start_bit;
      if (conv_done && !scan_mode)
         next_start = 1'b0;
      if (csr_wr)
         next_start = bus_wdata[CSR_START];
      if (trig_fall)
         next_start = 1'b1;
   end

   // control/status plain fields and start bit
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {end_irq_enable, conversion_start_bit, scan_mode} <= 3'b000;
         {speed_select, channel_select} <= 4'h0;
      end else if (standby) begin
         {end_irq_enable, conversion_start_bit, scan_mode} <= 3'b000;
         {speed_select, channel_select} <= 4'h0;
      end else begin
         conversion_start_bit <= next_start;
         if (csr_wr) begin
            end_irq_enable <= bus_wdata[CSR_IE];
            scan_mode      <= bus_wdata[CSR_SCAN];
            speed_select   <= bus_wdata[CSR_SPEED];
            channel_select <= bus_wdata[2:0];
         end
      end
   end

   // end flag: a set in the same cycle as a clear wins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         conversion_end_flag <= 1'b0;
         flag_armed          <= 1'b0;
      end else if (standby) begin
         conversion_end_flag <= 1'b0;
         flag_armed          <= 1'b0;
      end else begin
         if (flag_set)
            conversion_end_flag <= 1'b1;
         else if (csr_wr && !bus_wdata[CSR_FLAG] && flag_armed)
            conversion_end_flag <= 1'b0;
         if (csr_wr)
            flag_armed <= 1'b0;
         else if (csr_rd && conversion_end_flag)
            flag_armed <= 1'b1;
      end
   end

   // trigger enable; the other seven bits are constants
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         ext_start_enable <= 1'b0;
      else if (standby)
         ext_start_enable <= 1'b0;
      else if (bus_wr && bus_addr == ADDR_TRG)
         ext_start_enable <= bus_wdata[TRG_ENABLE];
   end

   // conversion sequencer; mode and speed are sampled live, so software
   // must stop conversion before changing them
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state    <= st_idle;
         cnt      <= '0;
         scan_idx <= '0;
      end else if (standby) begin
         state    <= st_idle;
         scan_idx <= '0;
      end else begin
         case (state)
            st_idle: begin
               if (conversion_start_bit) begin
                  state    <= st_run;
                  scan_idx <= '0;
                  cnt      <= speed_select ? LEN_FIRST_FAST : LEN_FIRST_SLOW;
               end
            end
            st_run: begin
               if (!conversion_start_bit)
                  state <= st_idle;
               else if (conv_done) begin
                  if (!scan_mode)
                     state <= st_idle;
                  else begin
                     scan_idx <= scan_last ? 2'd0 : scan_idx + 2'd1;
                     cnt      <= speed_select ? LEN_NEXT_FAST : LEN_NEXT_SLOW;
                  end
               end else if (state_tick)
                  cnt <= cnt - 9'd1;
            end
            default: state <= st_idle;
         endcase
      end
   end

   // results land in the register paired with the input's low two bits
   ads_result_mem u_mem (
      .clock   (clock),
      .rst     (rst),
      .clear   (standby),
      .wr_en   (conv_done),
      .wr_idx  (conv_idx[1:0]),
      .wr_data (ana_result),
      .rd_idx  (bus_addr[2:1]),
      .rd_data (mem_q)
   );

   // analogue side: channel lags the select by one clock, harmless since
   // sampling starts many states into the conversion
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         analog_channel <= '0;
         conv_active    <= 1'b0;
      end else begin
         analog_channel <= conv_idx;
         conv_active    <= state == st_run && conversion_start_bit;
      end
   end

   assign end_of_conversion_irq = conversion_end_flag && end_irq_enable;

   // read pipeline: strobe, then memory word ready, then byte out
   assign res_hit = rd_addr_q >= ADDR_RES_A_HI && rd_addr_q <= ADDR_RES_D_LO;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_q      <= 1'b0;
         rd_addr_q <= '0;
      end else begin
         rd_q <= bus_rd;
         if (bus_rd)
            rd_addr_q <= bus_addr;
      end
   end

   // holding latch for the lower byte, loaded by every upper byte read
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         temp_low <= '0;
      else if (standby)
         temp_low <= '0;
      else if (rd_q && res_hit && !rd_addr_q[0])
         temp_low <= mem_q[7:0];
   end

   // read data mux; unmapped addresses answer zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus_rdata  <= '0;
         bus_rvalid <= 1'b0;
      end else begin
         bus_rvalid <= rd_q;
         if (rd_q) begin
            if (res_hit)
               bus_rdata <= rd_addr_q[0] ? temp_low : mem_q[15:8];
            else if (rd_addr_q == ADDR_CSR)
               bus_rdata <= csr_value;
            else if (rd_addr_q == ADDR_TRG)
               bus_rdata <= trg_value;
            else
               bus_rdata <= UNMAPPED;
         end
      end
   end

   // helper for the length check: cycles since the first conversion began
   logic [9:0] run_cycles;
   logic       first_conv;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         run_cycles <= '0;
         first_conv <= 1'b0;
      end else if (state == st_idle) begin
         run_cycles <= '0;
         first_conv <= 1'b1;
      end else begin
         run_cycles <= run_cycles + 10'd1;
         if (conv_done)
            first_conv <= 1'b0;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_begin;
      state == st_idle && conversion_start_bit && !standby;
   endsequence

   sequence s_single_done;
      conv_done && !scan_mode && !standby && !csr_wr && !trig_fall;
   endsequence

   a_low_zero: assert property (rd_q && res_hit && rd_addr_q[0] |=> bus_rdata[5:0] == 6'h00)
      else $error("result lower byte reserved bits not zero");

   a_temp_copy: assert property (rd_q && res_hit && !rd_addr_q[0] && !standby
                                 |=> temp_low == $past(mem_q[7:0]))
      else $error("upper read did not load the holding latch");

   a_single_end: assert property (s_single_done |=> conversion_end_flag && !conversion_start_bit
                                  ##1 state == st_idle)
      else $error("single conversion did not end cleanly");

   a_flag_hold: assert property (conversion_end_flag && !flag_armed && !standby
                                 |=> conversion_end_flag)
      else $error("end flag cleared without a prior read");

   a_flag_one: assert property (!conversion_end_flag && !flag_set && !standby
                                |=> !conversion_end_flag)
      else $error("end flag set without a conversion end");

   a_irq_gate: assert property (conversion_end_flag && end_irq_enable
                                |-> end_of_conversion_irq)
      else $error("interrupt missing with flag and enable");

   a_irq_mask: assert property (!end_irq_enable |-> !end_of_conversion_irq)
      else $error("interrupt raised while disabled");

   a_trig_start: assert property (trig_fall && !standby |=> conversion_start_bit)
      else $error("trigger edge did not set start");

   a_trig_block: assert property (!ext_start_enable |-> !trig_fall)
      else $error("trigger passed while disabled");

   a_trig_quiet: assert property (!ext_start_enable && !conversion_start_bit && !csr_wr
                                  |=> !conversion_start_bit)
      else $error("start set while external start disabled");

   a_scan_restart: assert property (s_begin |=> state == st_run && scan_idx == 2'd0)
      else $error("scan did not restart at first channel");

   a_stop_idle: assert property (state == st_run && !conversion_start_bit && !standby
                                 |=> state == st_idle)
      else $error("clearing start did not stop conversion");

   a_first_len: assert property (conv_done && first_conv && !periph_half
                                 |-> run_cycles == (speed_select ? 10'(LEN_FIRST_FAST) - 10'd1
                                                                 : 10'(LEN_FIRST_SLOW) - 10'd1))
      else $error("first conversion length wrong");

   a_standby_clear: assert property (standby |=> csr_value == CSR_RESET && !ext_start_enable)
      else $error("standby did not clear control registers");

endmodule

/* logic/ads_pkg.sv */
/*
 package for the converter register block: bus addresses, csr field
 positions, reset values and conversion lengths in states.
 assumes one state equals one system clock when the peripheral clock
 runs at full rate.
*/
package ads_pkg;

   // byte addresses on the internal 8-bit bus
   localparam logic [15:0] ADDR_RES_A_HI = 16'hffe0;
   localparam logic [15:0] ADDR_RES_D_LO = 16'hffe7;
   localparam logic [15:0] ADDR_CSR      = 16'hffe8;
   localparam logic [15:0] ADDR_TRG      = 16'hffe9;

   // conv_control_status field positions
   localparam int CSR_FLAG  = 7;
   localparam int CSR_IE    = 6;
   localparam int CSR_START = 5;
   localparam int CSR_SCAN  = 4;
   localparam int CSR_SPEED = 3;
   localparam int CSR_GROUP = 2;

   // trigger_control field position and reset values
   localparam int          TRG_ENABLE   = 7;
   localparam logic [6:0]  TRG_RESERVED = 7'h7f;
   localparam logic [7:0]  CSR_RESET    = 8'h00;
   localparam logic [7:0]  UNMAPPED     = 8'h00;

   // result layout: left-justified, lsb of result at bit 6
   localparam int RES_WIDTH = 10;
   localparam int RES_LSB   = 6;

   // conversion lengths in states at full peripheral rate
   localparam logic [8:0] LEN_FIRST_SLOW = 9'd266;
   localparam logic [8:0] LEN_FIRST_FAST = 9'd134;
   localparam logic [8:0] LEN_NEXT_SLOW  = 9'd256;
   localparam logic [8:0] LEN_NEXT_FAST  = 9'd128;

endpackage

/* logic/ads_result_mem.sv */
/*
 four result words, written by the conversion engine and read with a
 registered read port; words come out left-justified in 16 bits.
 assumes a single clock shared with the register block.
*/
`timescale 1ns/100ps
module ads_result_mem
   import ads_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 clear,
   input  wire logic                 wr_en,
   input  wire logic [1:0]           wr_idx,
   input  wire logic [RES_WIDTH-1:0] wr_data,
   input  wire logic [1:0]           rd_idx,
   output logic      [15:0]          rd_data
);
   logic [RES_WIDTH-1:0] word [4];

   // one storage word per result register
   for (genvar i = 0; i < 4; i++) begin : g_word
      always_ff @(posedge clock or posedge rst) begin
         if (rst)
            word[i] <= '0;
         else if (clear)
            word[i] <= '0;
         else if (wr_en && wr_idx == 2'(i))
            word[i] <= wr_data;
      end
   end

   // low six bits are fixed zeros, so nothing can ever set them
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         rd_data <= '0;
      else
         rd_data <= {word[rd_idx], 6'h00};
   end
endmodule

/* logic/ads_trig_edge.sv */
/*
 external start pin: two-flop synchroniser, then a falling edge pulse
 gated by the enable bit.
 assumes the pin is asynchronous to clock and held at least two clocks.
*/
`timescale 1ns/100ps
module ads_trig_edge
   import ads_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic pin,
   input  wire logic enable,
   output logic      fall
);
   logic meta;
   logic sync;
   logic prev;

   // only sync looks at meta; the edge compares sync with prev
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta <= 1'b1;
         sync <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   assign fall = enable && prev && !sync;
endmodule

/* tb/ads_ana_model.sv */
/*
 behavioural analogue macro: offers a result that depends on the channel
 being converted and on a base value chosen by the bench.
 assumes ads_regs samples ana_result in the last state of a conversion.
*/
`timescale 1ns/100ps
module ads_ana_model
   import ads_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [2:0] analog_channel,
   input  wire logic       conv_active,
   input  wire logic [9:0] base,
   output logic      [9:0] ana_result
);
   // settled value while converting; outside a conversion the value toggles
   // every cycle so that a sample taken at the wrong moment cannot match
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ana_result <= 10'h000;
      end else if (conv_active) begin
         ana_result <= base + {7'h00, analog_channel} * 10'h007;
      end else begin
         ana_result <= ~ana_result;
      end
   end
endmodule

/* tb/testbench.sv */
/*
 self-checking bench for the converter register block: reset values,
 single conversions on all inputs, scans, external start and standby.
 assumes the one-cycle strobe bus of ads_regs and its analogue model.
*/
`timescale 1ns/100ps
module testbench;
   import ads_pkg::*;
   logic       clock = 0, rst = 1, standby = 0, periph_half = 0;
   logic       bus_wr = 0, bus_rd = 0, ext_start_pin = 1;
   logic [15:0] bus_addr = 16'h0000;
   logic [7:0] bus_wdata = 8'h00, bus_rdata, v, c;
   logic       bus_rvalid, conv_active, end_of_conversion_irq, sp, ie, g;
   logic [9:0] ana_result, base = 10'h000, res, len;
   logic [2:0] analog_channel, ac;
   logic [1:0] cnt;
   int         checks = 0, miscompares = 0, n;

   ads_regs i_ads_regs (.clock(clock), .rst(rst), .standby(standby), .periph_half(periph_half),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ext_start_pin(ext_start_pin),
      .ana_result(ana_result), .analog_channel(analog_channel), .conv_active(conv_active),
      .end_of_conversion_irq(end_of_conversion_irq));
   ads_ana_model i_ads_ana_model (.clock(clock), .rst(rst), .analog_channel(analog_channel),
      .conv_active(conv_active), .base(base), .ana_result(ana_result));

   always #5 clock = ~clock;

   // all stimulus moves 1 ns after the rising edge
   task tick;
      @(posedge clock);
      #1;
   endtask

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [15:0] a, input logic [7:0] d);
      tick;
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1;
      tick;
      bus_wr = 0;
   endtask

   // answer comes two cycles after the strobe; unknown if it never does
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      tick;
      bus_addr = a;
      bus_rd = 1;
      tick;
      bus_rd = 0;
      d = 8'hxx;
      for (int k = 0; k < 4; k++) begin
         if (bus_rvalid === 1'b1) begin
            d = bus_rdata;
            break;
         end
         tick;
      end
   endtask

   task automatic rchk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk({8'h00, d}, {8'h00, e});
   endtask

   function automatic logic [15:0] ra(input logic [1:0] idx, input logic lo);
      return ADDR_RES_A_HI + {13'h0000, idx, lo};
   endfunction

   function automatic logic [9:0] exp_res(input logic [9:0] b, input logic [2:0] ch);
      return b + {7'h00, ch} * 10'h007;
   endfunction

   // polling is bounded: a scan group ends well inside 1000 reads
   task automatic wait_flag(output logic [7:0] d);
      for (int i = 0; i < 1000; i++) begin
         rd(ADDR_CSR, d);
         if (d[7] === 1'b1) break;
      end
   endtask

   task automatic wait_active;
      for (int w = 0; w < 8 && conv_active !== 1'b1; w++) tick;
   endtask

   task give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #500000;
      miscompares++;
      give_verdict;
   end

   initial begin
      void'($urandom(37318));
      repeat (12) @(posedge clock);
      #1 rst = 0;
      // reset values, read-only results and an unmapped address
      rchk(ADDR_CSR, 8'h00);
      rchk(ADDR_TRG, 8'h7f);
      wr(ra(2'd0, 1'b1), 8'hff);
      for (int i = 0; i < 8; i++) rchk(ADDR_RES_A_HI + 16'(i), 8'h00);
      rchk(ra(2'd0, 1'b1), 8'h00);
      rchk(16'hffea, UNMAPPED);
      // single conversions on every input with random speed and enable
      for (int ch = 0; ch < 8; ch++) begin
         base = 10'($urandom);
         // first two inputs force both speed and enable values, the rest are random
         sp = (ch < 2) ? 1'(ch) : 1'($urandom);
         ie = (ch < 2) ? 1'(ch) : 1'($urandom);
         periph_half = (ch == 7);
         c = {2'b00, 1'b0, 1'b0, sp, 3'(ch)} | {1'b0, ie, 6'h00};
         wr(ADDR_CSR, c | 8'h20);
         wait_active;
         ac = analog_channel;
         n = 0;
         while (conv_active === 1'b1 && n < 1200) begin
            tick;
            n++;
         end
         chk({13'h0, ac}, 16'(ch));
         len = (sp ? 10'(LEN_FIRST_FAST) : 10'(LEN_FIRST_SLOW)) << periph_half;
         chk(16'(n <= len + 2 && n + 10 >= len), 16'h0001);
         res = exp_res(base, 3'(ch));
         rchk(ra(2'(ch), 1'b0), res[9:2]);
         rchk(ra(2'(ch + 1), 1'b1), {res[1:0], 6'h00});
         chk({15'h0, end_of_conversion_irq}, {15'h0, ie});
         rchk(ADDR_CSR, c | 8'h80);
         wr(ADDR_CSR, c | 8'h80);
         wr(ADDR_CSR, c);
         rchk(ADDR_CSR, c | 8'h80);
         wr(ADDR_CSR, c);
         rchk(ADDR_CSR, c);
         chk({15'h0, end_of_conversion_irq}, 16'h0000);
      end
      periph_half = 0;
      // scans, the last one over a full group, stopped in mid-group
      for (int k = 0; k < 2; k++) begin
         g = 1'($urandom);
         cnt = k ? 2'd3 : 2'($urandom);
         base = 10'($urandom);
         c = {3'b001, 1'b1, 1'b1, g, cnt};
         wr(ADDR_CSR, c);
         wait_flag(v);
         chk({8'h00, v}, {8'h00, c | 8'h80});
         for (int i = 0; i <= cnt; i++) begin
            res = exp_res(base, {g, 2'(i)});
            rchk(ra(2'(i), 1'b0), res[9:2]);
         end
         repeat (300) tick;
         chk({15'h0, conv_active}, 16'h0001);
         wr(ADDR_CSR, c & 8'h5f);
         repeat (3) tick;
         chk({15'h0, conv_active}, 16'h0000);
         wr(ADDR_CSR, c);
         wait_active;
         chk({13'h0, analog_channel}, {13'h0, g, 2'b00});
         wr(ADDR_CSR, c & 8'h5f);
      end
      // external start: blocked, then allowed
      repeat (4) tick;
      wr(ADDR_TRG, 8'h00);
      wr(ADDR_CSR, 8'h08);
      ext_start_pin = 0;
      repeat (8) tick;
      chk({15'h0, conv_active}, 16'h0000);
      ext_start_pin = 1;
      wr(ADDR_TRG, 8'h80);
      rchk(ADDR_TRG, 8'hff);
      base = 10'($urandom);
      repeat (3) tick;
      ext_start_pin = 0;
      wait_active;
      chk({15'h0, conv_active}, 16'h0001);
      ext_start_pin = 1;
      wait_flag(v);
      chk({8'h00, v}, 16'h0088);
      res = exp_res(base, 3'd0);
      rchk(ra(2'd0, 1'b0), res[9:2]);
      // standby in the middle of a scan clears the control, trigger and result registers
      wr(ADDR_CSR, 8'h78);
      repeat (200) tick;
      standby = 1;
      repeat (2) tick;
      standby = 0;
      chk({15'h0, conv_active}, 16'h0000);
      rchk(ADDR_CSR, CSR_RESET);
      rchk(ADDR_TRG, 8'h7f);
      rchk(ra(2'd0, 1'b0), 8'h00);
      give_verdict;
   end
endmodule
